// ==== i2c_seq_cfg.svh ====
// constants for the two-wire bus sequencer, status and address mask block
// What this block does
// - acknowledge bit driven from ack value select
// - ack request runs sequence, then self-clears
// - receive request takes one byte, self-clears
// - stop request makes Stop, then self-clears
// - restart request makes Repeated Start, self-clears
// - start request makes Start, then self-clears
// - start flag set on Start, cleared on Stop
// - slave direction flag updated after address byte
// - receive full set on byte, cleared by read
// - transmit full set by write, cleared when sent
// - set mask bits exclude address bits from compare
// - mask upper six bits read zero, reset zero
`ifndef I2C_SEQ_CFG_SVH
`define I2C_SEQ_CFG_SVH
`define OFF_CTL 8'h00
`define OFF_STAT 8'h04
`define OFF_MASK 8'h08
`define OFF_RCV 8'h0C
`define OFF_TRN 8'h10
`define OFF_OWN 8'h14
`define OFF_DIV 8'h18
`define OFF_IRQ 8'h1C
`define OFF_IEN 8'h20
`define CTL_EN 15
`define CTL_ACK_VALUE_SELECT 5
`define REQ_ACK 4
`define REQ_RX 3
`define REQ_STOP 2
`define REQ_RSTART 1
`define REQ_START 0
`define ST_ACKSTAT 15
`define ST_TRSTAT 14
`define ST_WCOL 7
`define ST_OV 6
`define ST_STOP 4
`define ST_START 3
`define ST_DIR 2
`define ST_RBF 1
`define ST_TBF 0
`define MSK_W 10
`define OWN_W 10
`define IRQ_DONE 0
`define IRQ_RX 1
`define IRQ_MATCH 2
`define IRQ_STOP 3
`define IRQ_W 4
`define DIV_RST 16'h0018
`define PH_FIRST 2'h0
`define PH_HIGH 2'h1
`define PH_SAMPLE 2'h2
`define PH_LAST 2'h3
`define TX_LAST 4'h8
`define RX_LAST 4'h7
`define SLV_ADDR 4'h8
`define SLV_ACK 4'h9
`endif

// ==== i2c_seq_pkg.sv ====
// types shared by the two-wire bus sequencer
package i2c_seq_pkg;
	typedef enum logic [6:0] {
		M_IDLE = 7'h01,
		M_START = 7'h02,
		M_RSTART = 7'h04,
		M_STOP = 7'h08,
		M_TX = 7'h10,
		M_RX = 7'h20,
		M_ACK = 7'h40
	} mstate_t;
endpackage

// ==== i2c_seq.sv ====
// two-wire bus controller: master sequencer, status flags, slave address mask, wishbone registers
`timescale 1ns/1ps
`include "i2c_seq_cfg.svh"
module i2c_seq
	import i2c_seq_pkg::*;
#(
	parameter int DIV_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic irq_o
);
	if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div
		$error("DIV_W must lie in 2..16");
	end

	logic wb_ack_q;
	logic [15:0] rd_d;
	logic en_q, ack_value_select_q;
	logic [4:0] req_q;
	logic tbf_q, rbf_q, ov_q, wcol_q, ackstat_q, dir_q, start_seen_q, stop_seen_q;
	logic [`MSK_W-1:0] mask_q;
	logic [`OWN_W-1:0] own_q;
	logic [DIV_W-1:0] div_q, cnt_q;
	logic [7:0] rcv_q, trn_q, sh_q, ssh_q;
	logic [`IRQ_W-1:0] irq_q, ien_q, irq_set;
	logic [2:0] scl_s, sda_s;
	logic scl_q, sda_q, scl_p, sda_p;
	logic m_scl_q, m_sda_q, slv_ack_q, slv_act_q;
	logic [3:0] bit_q, scnt_q;
	logic [1:0] ph_q;
	mstate_t st_q;

	wire acc = wb_cyc_i & wb_stb_i & wb_ack_q;
	wire wr = acc & wb_we_i;
	wire rd = acc & ~wb_we_i;
	wire wr_ctl = wr & (wb_adr_i == `OFF_CTL);
	wire wr_trn = wr & (wb_adr_i == `OFF_TRN) & wb_sel_i[0];
	wire rd_rcv = rd & (wb_adr_i == `OFF_RCV);
	wire rd_irq = rd & (wb_adr_i == `OFF_IRQ);
	wire tick = (st_q != M_IDLE) && (cnt_q == div_q);
	wire bit_st = (st_q == M_TX) || (st_q == M_RX) || (st_q == M_ACK);
	// wait in the released-clock phase until the line is seen high, so a stretching slave holds us
	wire stretch = (ph_q == `PH_SAMPLE) && !scl_q && (bit_st || st_q == M_RSTART || st_q == M_STOP);
	wire adv = tick && !stretch;
	wire last = (st_q == M_TX) ? (bit_q == `TX_LAST) : (st_q == M_RX) ? (bit_q == `RX_LAST) : 1'b1;
	wire fin = adv && (ph_q == `PH_LAST) && last;
	wire start_det = scl_q && scl_p && sda_p && !sda_q;
	wire stop_det = scl_q && scl_p && !sda_p && sda_q;
	wire scl_rise = scl_q && !scl_p;
	wire scl_fall = !scl_q && scl_p;
	// masked address bits drop out of the compare
	wire match = (((ssh_q[7:1] ^ own_q[6:0]) & ~mask_q[6:0]) == 7'h00);

	// wishbone classic: ack one cycle after strobe, effects at the ack edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_q <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_q <= wb_cyc_i & wb_stb_i & ~wb_ack_q;
			if (wb_cyc_i & wb_stb_i & ~wb_ack_q) begin
				wb_dat_o <= {16'h0000, rd_d};
			end
		end
	end
	assign wb_ack_o = wb_ack_q;

	always_comb begin
		rd_d = 16'h0000;
		unique case (wb_adr_i)
			`OFF_CTL: begin
				rd_d[`CTL_EN] = en_q;
				rd_d[`CTL_ACK_VALUE_SELECT] = ack_value_select_q;
				rd_d[4:0] = req_q;
			end
			`OFF_STAT: begin
				rd_d[`ST_ACKSTAT] = ackstat_q;
				rd_d[`ST_TRSTAT] = (st_q == M_TX);
				rd_d[`ST_WCOL] = wcol_q;
				rd_d[`ST_OV] = ov_q;
				rd_d[`ST_STOP] = stop_seen_q;
				rd_d[`ST_START] = start_seen_q;
				rd_d[`ST_DIR] = dir_q;
				rd_d[`ST_RBF] = rbf_q;
				rd_d[`ST_TBF] = tbf_q;
			end
			`OFF_MASK: rd_d[`MSK_W-1:0] = mask_q;
			`OFF_RCV: rd_d[7:0] = rcv_q;
			`OFF_TRN: rd_d[7:0] = trn_q;
			`OFF_OWN: rd_d[`OWN_W-1:0] = own_q;
			`OFF_DIV: rd_d[DIV_W-1:0] = div_q;
			`OFF_IRQ: rd_d[`IRQ_W-1:0] = irq_q;
			`OFF_IEN: rd_d[`IRQ_W-1:0] = ien_q;
			default: rd_d = 16'h0000;
		endcase
	end

	// control register; request bits clear themselves when their sequence ends
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_q <= 1'b0;
			ack_value_select_q <= 1'b0;
			req_q <= 5'h00;
		end else begin
			if (wr_ctl && wb_sel_i[1]) begin
				en_q <= wb_dat_i[`CTL_EN];
			end
			// a high-byte-only write must not swallow a sequence end
			if (wr_ctl && wb_sel_i[0]) begin
				ack_value_select_q <= wb_dat_i[`CTL_ACK_VALUE_SELECT];
				req_q <= wb_dat_i[4:0];
			end else if (fin) begin
				if (st_q == M_START) req_q[`REQ_START] <= 1'b0;
				if (st_q == M_RSTART) req_q[`REQ_RSTART] <= 1'b0;
				if (st_q == M_STOP) req_q[`REQ_STOP] <= 1'b0;
				if (st_q == M_RX) req_q[`REQ_RX] <= 1'b0;
				if (st_q == M_ACK) req_q[`REQ_ACK] <= 1'b0;
			end
		end
	end

	// plain configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= '0;
			own_q <= '0;
			div_q <= DIV_W'(`DIV_RST);
			ien_q <= '0;
		end else if (wr) begin
			unique case (wb_adr_i)
				`OFF_MASK: begin
					if (wb_sel_i[0]) mask_q[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) mask_q[`MSK_W-1:8] <= wb_dat_i[`MSK_W-1:8];
				end
				`OFF_OWN: begin
					if (wb_sel_i[0]) own_q[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) own_q[`OWN_W-1:8] <= wb_dat_i[`OWN_W-1:8];
				end
				`OFF_DIV: if (wb_sel_i[0]) div_q <= wb_dat_i[DIV_W-1:0];
				`OFF_IEN: if (wb_sel_i[0]) ien_q <= wb_dat_i[`IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// transmit buffer: a write while the bus is busy is a collision
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trn_q <= 8'h00;
			tbf_q <= 1'b0;
			wcol_q <= 1'b0;
		end else begin
			if (wr_trn && st_q == M_IDLE && !tbf_q) begin
				trn_q <= wb_dat_i[7:0];
				tbf_q <= 1'b1;
			end else if (fin && st_q == M_TX) begin
				tbf_q <= 1'b0;
			end
			if (wr_trn && (st_q != M_IDLE || tbf_q)) begin
				wcol_q <= 1'b1;
			end else if (wr & (wb_adr_i == `OFF_STAT) & wb_sel_i[0] & ~wb_dat_i[`ST_WCOL]) begin
				wcol_q <= 1'b0;
			end
		end
	end

	// receive buffer; a new byte wins over a read in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rcv_q <= 8'h00;
			rbf_q <= 1'b0;
			ov_q <= 1'b0;
		end else if (fin && st_q == M_RX) begin
			rcv_q <= sh_q;
			rbf_q <= 1'b1;
			ov_q <= ov_q | rbf_q;
		end else if (rd_rcv) begin
			rbf_q <= 1'b0;
		end
	end

	// quarter-bit enable from the divider, only while a sequence runs
	always_ff @(posedge clk_i) begin
		if (rst_i || st_q == M_IDLE || tick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// pin sampling: a level counts once the second and third stage agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_s <= {scl_s[1:0], scl_i};
			sda_s <= {sda_s[1:0], sda_i};
			if (scl_s[1] == scl_s[2]) scl_q <= scl_s[2];
			if (sda_s[1] == sda_s[2]) sda_q <= sda_s[2];
			scl_p <= scl_q;
			sda_p <= sda_q;
		end
	end

	// bus condition flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b0;
		end else if (start_det) begin
			start_seen_q <= 1'b1;
			stop_seen_q <= 1'b0;
		end else if (stop_det) begin
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b1;
		end
	end

	// master sequencer; m_*_q high means the pin is pulled low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= M_IDLE;
			ph_q <= `PH_FIRST;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			m_scl_q <= 1'b0;
			m_sda_q <= 1'b0;
			ackstat_q <= 1'b0;
		end else if (st_q == M_IDLE) begin
			ph_q <= `PH_FIRST;
			bit_q <= 4'h0;
			if (en_q) begin
				if (req_q[`REQ_START]) st_q <= M_START;
				else if (req_q[`REQ_RSTART]) st_q <= M_RSTART;
				else if (req_q[`REQ_STOP]) st_q <= M_STOP;
				else if (req_q[`REQ_RX]) st_q <= M_RX;
				else if (req_q[`REQ_ACK]) st_q <= M_ACK;
				else if (tbf_q) begin
					st_q <= M_TX;
					sh_q <= trn_q;
				end
			end
		end else if (adv) begin
			ph_q <= ph_q + 2'h1;
			unique case (st_q)
				M_START: begin
					unique case (ph_q)
						`PH_FIRST: {m_scl_q, m_sda_q} <= 2'b00;
						`PH_HIGH: m_sda_q <= 1'b1;
						`PH_SAMPLE: m_scl_q <= 1'b1;
						`PH_LAST: st_q <= M_IDLE;
					endcase
				end
				M_RSTART: begin
					unique case (ph_q)
						`PH_FIRST: m_sda_q <= 1'b0;
						`PH_HIGH: m_scl_q <= 1'b0;
						`PH_SAMPLE: m_sda_q <= 1'b1;
						`PH_LAST: begin
							m_scl_q <= 1'b1;
							st_q <= M_IDLE;
						end
					endcase
				end
				M_STOP: begin
					unique case (ph_q)
						`PH_FIRST: m_sda_q <= 1'b1;
						`PH_HIGH: m_scl_q <= 1'b0;
						`PH_SAMPLE: m_sda_q <= 1'b0;
						`PH_LAST: st_q <= M_IDLE;
					endcase
				end
				default: begin
					unique case (ph_q)
						`PH_FIRST: begin
							if (st_q == M_ACK) m_sda_q <= ~ack_value_select_q;
							else if (st_q == M_TX && bit_q != `TX_LAST) m_sda_q <= ~sh_q[7];
							else m_sda_q <= 1'b0;
						end
						`PH_HIGH: m_scl_q <= 1'b0;
						`PH_SAMPLE: begin
							if (st_q == M_RX) sh_q <= {sh_q[6:0], sda_q};
							if (st_q == M_TX && bit_q == `TX_LAST) ackstat_q <= sda_q;
						end
						`PH_LAST: begin
							m_scl_q <= 1'b1;
							bit_q <= bit_q + 4'h1;
							if (st_q == M_TX) sh_q <= {sh_q[6:0], 1'b0};
							if (last) st_q <= M_IDLE;
						end
					endcase
				end
			endcase
		end
	end

	// slave address receiver; tracks the address byte only, while the master is idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slv_act_q <= 1'b0;
			slv_ack_q <= 1'b0;
			scnt_q <= 4'h0;
			ssh_q <= 8'h00;
			dir_q <= 1'b0;
		end else if (start_det) begin
			slv_act_q <= (st_q == M_IDLE) && en_q;
			slv_ack_q <= 1'b0;
			scnt_q <= 4'h0;
		end else if (stop_det) begin
			slv_act_q <= 1'b0;
			slv_ack_q <= 1'b0;
		end else if (slv_act_q) begin
			if (scl_rise && scnt_q < `SLV_ADDR) begin
				ssh_q <= {ssh_q[6:0], sda_q};
				scnt_q <= scnt_q + 4'h1;
			end else if (scl_fall && scnt_q == `SLV_ADDR) begin
				scnt_q <= `SLV_ACK;
				slv_ack_q <= match;
				slv_act_q <= match;
				if (match) dir_q <= ssh_q[0];
			end else if (scl_fall && scnt_q == `SLV_ACK) begin
				slv_ack_q <= 1'b0;
				slv_act_q <= 1'b0;
			end
		end
	end

	// open-drain pins: only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = m_scl_q;
	assign sda_oe_o = m_sda_q | slv_ack_q;

	// interrupt status: read clears only what the read returned, so a later event survives
	assign irq_set = {stop_det, slv_act_q & scl_fall & (scnt_q == `SLV_ADDR) & match,
		fin & (st_q == M_RX), fin};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= '0;
		end else begin
			irq_q <= (irq_q & ~(rd_irq ? wb_dat_o[`IRQ_W-1:0] : {`IRQ_W{1'b0}})) | irq_set;
		end
	end
	assign irq_o = |(irq_q & ien_q);

	chk_ack_value: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q == M_ACK && ph_q == `PH_SAMPLE) |-> (sda_oe_o == ~ack_value_select_q))
		else $error("ack bit does not follow ack value select");
	chk_ack_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		($fell(req_q[`REQ_ACK]) && !$past(wr_ctl)) |-> ($past(st_q) == M_ACK && st_q == M_IDLE))
		else $error("ack request cleared outside its sequence end");
	chk_rx_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		($fell(req_q[`REQ_RX]) && !$past(wr_ctl)) |-> (rbf_q && $past(bit_q) == `RX_LAST))
		else $error("receive request cleared before eighth bit");
	chk_stop_end: assert property (@(posedge clk_i) disable iff (rst_i)
		($fell(req_q[`REQ_STOP]) && !$past(wr_ctl)) |-> (!scl_oe_o && !m_sda_q))
		else $error("stop request cleared with bus not released");
	chk_rstart_end: assert property (@(posedge clk_i) disable iff (rst_i)
		($fell(req_q[`REQ_RSTART]) && !$past(wr_ctl)) |-> (scl_oe_o && m_sda_q))
		else $error("restart request cleared with lines not held low");
	chk_start_end: assert property (@(posedge clk_i) disable iff (rst_i)
		($fell(req_q[`REQ_START]) && !$past(wr_ctl)) |-> (scl_oe_o && m_sda_q && $past(st_q) == M_START))
		else $error("start request cleared with lines not held low");
	chk_start_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		(start_det |=> start_seen_q) and (stop_det && !start_det |=> !start_seen_q))
		else $error("start flag does not track last bus condition");
	chk_dir_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		(slv_act_q && scl_fall && scnt_q == `SLV_ADDR && match && !start_det && !stop_det)
		|=> (dir_q == $past(ssh_q[0])))
		else $error("direction flag not taken from address byte");
	chk_rbf_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_rcv && !(fin && st_q == M_RX)) |=> !rbf_q)
		else $error("receive full not cleared by read");
	chk_tbf_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q == M_TX && !fin) |=> tbf_q)
		else $error("transmit full dropped during transmission");
	chk_mask_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_ack_q && wb_adr_i == `OFF_MASK && !wb_we_i) |-> (wb_dat_o[15:10] == 6'h00))
		else $error("mask upper bits read nonzero");
endmodule

// ==== i2c_peer.sv ====
// remote bus party: a slave answering the controller and a remote master for address tests
`timescale 1ns/1ps
module i2c_peer #(
	parameter logic [6:0] PEER_ADDR = 7'h50
) (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [7:0] rd_byte_i,
	output logic scl_pull_o,
	output logic sda_pull_o,
	output logic ack_seen_o
);
	logic m_scl = 1'b0;
	logic m_sda = 1'b0;
	logic s_sda = 1'b0;
	logic adr = 1'b0;
	logic sel = 1'b0;
	logic rd = 1'b0;
	logic [7:0] sh = 8'h00;
	int n = 0;
	// released lines float to the pull-up level
	assign scl_pull_o = m_scl;
	assign sda_pull_o = m_sda | s_sda;
	always @(negedge sda_i or posedge sda_i) begin
		if (scl_i === 1'b1) begin
			n = 0;
			// fall is a start, rise a stop
			adr = ~sda_i;
			rd = 1'b0;
			s_sda = 1'b0;
		end
	end
	always @(posedge scl_i) begin
		if (n < 8) sh = {sh[6:0], sda_i};
		else if (rd) begin
			ack_seen_o = sda_i;
			// a not-acknowledge ends the read
			rd = ~sda_i;
		end
		n = (n == 8) ? 0 : n + 1;
	end
	// data only changes while the clock is low
	always @(negedge scl_i) begin
		if (n == 8 && adr) begin
			sel = (sh[7:1] == PEER_ADDR);
			rd = sel & sh[0];
			adr = 1'b0;
			s_sda = sel;
		end else if (n == 8) s_sda = sel & ~rd;
		else if (n == 0) s_sda = rd & ~rd_byte_i[7];
		else if (rd) s_sda = ~rd_byte_i[7 - n];
	end
	// clock stands still outside the frame; 125 ns period inside it
	task automatic host_addr(input logic [7:0] b, output logic ack);
		m_sda = 1'b1;
		#62.5 m_scl = 1'b1;
		for (int i = 7; i >= -1; i--) begin
			#31.25 m_sda = (i >= 0) ? ~b[i] : 1'b0;
			#31.25 m_scl = 1'b0;
			#31.25 ack = ~sda_i;
			#31.25 m_scl = 1'b1;
		end
		#31.25 m_sda = 1'b1;
		#31.25 m_scl = 1'b0;
		#62.5 m_sda = 1'b0;
		#125;
	endtask
endmodule

// ==== tb.sv ====
// self-checking bench: registers, master sequences, interrupts and slave address match
`timescale 1ns/1ps
`include "i2c_seq_cfg.svh"
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [7:0] rx_byte = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] q, m, e;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [3:0] sel = 4'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, scl_oe, sda_oe, p_scl, p_sda, p_ack, irq_o, scl_w, sda_w, rw, ack;
	logic scl_od, sda_od;
	int errors = 0;
	int tests_run = 0;
	int k;
	// a pin shows the driven level while enabled, else the pull-up
	assign scl_w = (scl_oe ? scl_od : 1'b1) & ~p_scl;
	assign sda_w = (sda_oe ? sda_od : 1'b1) & ~p_sda;
	initial forever #5 clk_i = ~clk_i;
	i2c_seq dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w), .scl_o(scl_od),
		.scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_od), .sda_oe_o(sda_oe), .irq_o(irq_o));
	i2c_peer peer_u (.scl_i(scl_w), .sda_i(sda_w), .rd_byte_i(rx_byte), .scl_pull_o(p_scl), .sda_pull_o(p_sda),
		.ack_seen_o(p_ack));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic summarize();
		$display("tests_run=%0d errors=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic stall();
		errors++;
		summarize();
	endtask
	// reads note their expectation; a zero mask marks a read that is not compared
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] mk);
		int n;
		n = 0;
		if (!w) exp_q.push_back(d);
		if (!w) msk_q.push_back(mk);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= w ? d : 32'h0;
		sel <= 4'h3;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) stall();
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && we === 1'b0 && msk_q.size() > 0) begin
			m = msk_q.pop_front();
			e = exp_q.pop_front();
			if (m != 0) check(wb_dat_o & m, e & m);
		end
	end
	task automatic poll(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] want);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 32'h0, 32'h0);
			n++;
		end while ((q & mk) !== want && n < 3000);
		if (n >= 3000) stall();
	endtask
	// request a sequence, see it pending, then wait for hardware to clear it
	task automatic seq(input int b, input logic [31:0] base);
		bus(1'b1, `OFF_CTL, base | (32'h1 << b), 32'h0);
		bus(1'b0, `OFF_CTL, 32'h1 << b, 32'h1 << b);
		poll(`OFF_CTL, 32'h1 << b, 32'h0);
	endtask
	task automatic irq_is(input logic v);
		repeat (2) @(posedge clk_i);
		check({31'h0, irq_o}, {31'h0, v});
	endtask
	initial begin
		void'($urandom(61816));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, `OFF_MASK, 32'h0, 32'hFFFF);
		bus(1'b0, `OFF_STAT, 32'h0, 32'hFFFF);
		bus(1'b0, `OFF_DIV, `DIV_RST, 32'hFFFF);
		bus(1'b0, 8'h30, 32'h0, 32'hFFFFFFFF);
		bus(1'b1, `OFF_MASK, 32'hFFFF, 32'h0);
		bus(1'b0, `OFF_MASK, 32'h03FF, 32'hFFFF);
		bus(1'b1, `OFF_OWN, 32'h2A, 32'h0);
		$display("registers test done");
		rx_byte <= 8'($urandom());
		seq(`REQ_START, 32'h8000);
		bus(1'b0, `OFF_STAT, 32'h08, 32'h18);
		irq_is(1'b0);
		bus(1'b1, `OFF_IEN, 32'h1, 32'h0);
		irq_is(1'b1);
		bus(1'b0, `OFF_IRQ, 32'h1, 32'h1);
		irq_is(1'b0);
		bus(1'b1, `OFF_TRN, 32'hA1, 32'h0);
		bus(1'b0, `OFF_STAT, 32'h1, 32'h1);
		bus(1'b1, `OFF_TRN, 32'h5C, 32'h0);
		bus(1'b0, `OFF_STAT, 32'h81, 32'h81);
		bus(1'b1, `OFF_STAT, 32'h0, 32'h0);
		bus(1'b0, `OFF_STAT, 32'h0, 32'h80);
		poll(`OFF_STAT, 32'h1, 32'h0);
		bus(1'b0, `OFF_STAT, 32'h0, 32'h8000);
		seq(`REQ_RX, 32'h8000);
		bus(1'b0, `OFF_STAT, 32'h2, 32'h2);
		bus(1'b0, `OFF_RCV, {24'h0, rx_byte}, 32'hFF);
		bus(1'b0, `OFF_STAT, 32'h0, 32'h2);
		seq(`REQ_ACK, 32'h8000);
		check({31'h0, p_ack}, 32'h0);
		seq(`REQ_RX, 32'h8000);
		seq(`REQ_ACK, 32'h8020);
		check({31'h0, p_ack}, 32'h1);
		seq(`REQ_RSTART, 32'h8000);
		bus(1'b0, `OFF_STAT, 32'h08, 32'h18);
		seq(`REQ_STOP, 32'h8000);
		bus(1'b0, `OFF_STAT, 32'h10, 32'h18);
		$display("master test done");
		bus(1'b1, `OFF_IEN, 32'h4, 32'h0);
		for (int j = 0; j < 3; j++) begin
			k = $urandom_range(6, 0);
			rw = 1'($urandom_range(1, 0));
			bus(1'b1, `OFF_MASK, (j == 1) ? (32'h1 << k) : 32'h0, 32'h0);
			bus(1'b0, `OFF_IRQ, 32'h0, 32'h0);
			peer_u.host_addr({7'h2A ^ ((j == 0) ? 7'h0 : (7'h1 << k)), rw}, ack);
			check({31'h0, ack}, {31'h0, j != 2});
			bus(1'b0, `OFF_IRQ, (j != 2) ? 32'h4 : 32'h0, 32'h4);
			if (j != 2) bus(1'b0, `OFF_STAT, {29'h0, rw, 2'h0}, 32'h4);
		end
		$display("slave test done");
		summarize();
	end
endmodule
